// ==== logic/video_decoder_channel_controls_map.vh ====
`ifndef VIDEO_DECODER_CHANNEL_CONTROLS_MAP_VH
`define VIDEO_DECODER_CHANNEL_CONTROLS_MAP_VH

// ----------------------------------------------------------------------
// Serial bus slave address
// ----------------------------------------------------------------------
`define SLAVE_ADDR_HIGH 5'h0A

// ----------------------------------------------------------------------
// Per-channel register offsets (channel n at (n - 1) * 0x10)
// ----------------------------------------------------------------------
`define OFS_VIDEO_STATUS 4'h0
`define OFS_INPUT_FORMAT_CONTROL 4'h1
`define OFS_HORIZ_START_LOW 4'h2
`define OFS_HORIZ_WIDTH_LOW 4'h3
`define OFS_VERT_START_LOW 4'h4
`define OFS_VERT_HEIGHT_LOW 4'h5
`define OFS_WINDOW_UPPER_BITS 4'h6
`define OFS_HUE_ADJUST 4'h7
`define OFS_SATURATION_ADJUST 4'h8
`define OFS_CONTRAST_ADJUST 4'h9
`define OFS_BRIGHTNESS_ADJUST 4'hA
`define OFS_LUMA_FILTER_CONTROL 4'hB
`define OFS_CHROMA_KILL_TRANSIENT 4'hC
`define OFS_CHANNEL_OUTPUT_CONTROL 4'hD
`define OFS_TEST_MODE_RESERVED 4'hE

// ----------------------------------------------------------------------
// Shared register offsets
// ----------------------------------------------------------------------
`define ADDR_FIELD_VERT_HEIGHT_STATUS 8'h40
`define ADDR_WHITE_PEAK_MODES 8'h41
`define ADDR_WHITE_PEAK_PARAMS 8'h42
`define ADDR_MISC_OUTPUT_CONTROL 8'h43

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_INPUT_FORMAT_CONTROL 8'h00
`define RST_HORIZ_START_LOW 8'h20
`define RST_HORIZ_WIDTH_LOW 8'hD0
`define RST_VERT_START_LOW 8'h06
`define RST_VERT_HEIGHT_LOW 8'hF0
`define RST_WINDOW_UPPER_BITS 8'h08
`define RST_PICTURE_ADJUST 8'h80
`define RST_LUMA_FILTER_CONTROL 8'h00
`define RST_CHROMA_KILL_TRANSIENT 8'h06
`define RST_CHANNEL_OUTPUT_CONTROL 8'h00
`define RST_TEST_MODE_RESERVED 8'h11
`define RST_WHITE_PEAK_MODES 8'h00
`define RST_WHITE_PEAK_PARAMS 8'h00
`define RST_MISC_OUTPUT_CONTROL 8'h00

// ----------------------------------------------------------------------
// Writable bit masks
// ----------------------------------------------------------------------
`define WMASK_INPUT_FORMAT_CONTROL 8'hFC
`define WMASK_WINDOW_UPPER_BITS 8'h3F
`define WMASK_CHROMA_KILL_TRANSIENT 8'h3F
`define WMASK_CHANNEL_OUTPUT_CONTROL 8'h67

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_MANUAL_STANDARD 7
`define BIT_GAIN_LOOP_ENABLE 3
`define BIT_SETUP_LEVEL 2
`define BIT_BACKGROUND_ENABLE 6
`define BIT_BACKGROUND_COLOUR 5
`define BIT_SOFT_RESET 3
`define BIT_DUAL_OUTPUT 2
`define BIT_OUTPUT_ENABLE 7

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define SOFT_RST_CYCLES 3'h4

`endif

// ==== logic/video_decoder_channel_controls.v ====
// Summary of operation
// - Per-channel read-only lock, nonstandard and 60Hz flags read 1 when true.
// - Manual bit 0 follows detected standard; 1 uses forced standard field.
// - Forced standard codes 0..6; also free-run standard with no video in auto.
// - Gain loop enable defaults off; setup bit picks 0 or 7.5 IRE as code 16.
// - Horizontal start 10 bits, default 32, low byte 0x02, upper bits 1:0.
// - Horizontal width 10 bits, default 720, low byte 0x03, upper bits 3:2.
// - Vertical start 9 bits, default 6, low byte 0x04, ninth bit 4.
// - Vertical height 9 bits, default 240, low byte 0x05, ninth bit 5.
// - Hue 8 bits, 1.4 degrees per step, default 128 means zero.
// - Saturation and contrast 8 bits, 0.8% per step, default 128 unity.
// - Brightness 8 bits, 0.2 IRE per step, default 128 zero offset.
// - Separation mode 0,1 comb, 2 trap; trap bandwidth narrow by default.
// - Peaking band bit and 4-bit peaking gain at 12.5% per code.
// - Colour kill auto/never/always; transient gain 4 bits default 6.
// - Background enable shows flat colour; colour bit blue or black.
// - Soft reset bit resets processing, keeps registers, clears itself.
// - Dual output bit and 2-bit partner channel select.
// - Sync status: field flags bits 7:4, vertical active bits 3:0.
// - Per-channel 2-bit white peak mode, channel 1 in lowest pair.
// - 2-bit channel tag format for multiplexed output, default none.
// - White peak reference, range and time constant, time default slowest.
// - Output enable 0 by default tri-states video and sync, not clocks.
// - Output enable 1 drives video and sync outputs.
`include "video_decoder_channel_controls_map.vh"

module video_decoder_channel_controls #(
  parameter SOFT_RST_CYCLES = `SOFT_RST_CYCLES
) (
  // Clock, reset, enable
  input wire clk_in,
  input wire sys_rst_in,
  input wire ce_in,
  // Serial host pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_out,
  input wire [1:0] slave_addr_sel_in,
  // Decoder core status, four channels packed, channel 1 lowest
  input wire [11:0] det_standard_in,
  input wire [3:0] colour_detected_in,
  input wire [3:0] colour_loop_locked_in,
  input wire [3:0] gain_loop_locked_in,
  input wire [3:0] clamp_loop_locked_in,
  input wire [3:0] hpll_locked_in,
  input wire [3:0] nonstandard_input_in,
  input wire [3:0] field_rate_sixty_in,
  input wire [3:0] no_video_in,
  input wire [3:0] field_flag_in,
  input wire [3:0] vert_active_flag_in,
  // Standard and front-end controls
  output reg [11:0] active_standard_out,
  output wire [3:0] gain_loop_enable_out,
  output wire [3:0] setup_level_select_out,
  // Active window
  output wire [39:0] horiz_start_out,
  output wire [39:0] horiz_width_out,
  output wire [35:0] vert_start_out,
  output wire [35:0] vert_height_out,
  // Picture adjustments
  output wire [31:0] hue_out,
  output wire [31:0] saturation_gain_out,
  output wire [31:0] contrast_gain_out,
  output wire [31:0] brightness_offset_out,
  // Luma and chroma filters
  output wire [3:0] trap_bandwidth_out,
  output wire [7:0] separation_mode_out,
  output wire [3:0] peaking_band_out,
  output wire [15:0] peaking_gain_out,
  output wire [7:0] colour_kill_mode_out,
  output wire [15:0] transient_gain_out,
  // Channel output control
  output reg [3:0] background_active_out,
  output reg [3:0] background_black_out,
  output reg [3:0] soft_reset_out,
  output wire [3:0] dual_output_enable_out,
  output wire [7:0] partner_channel_select_out,
  // Shared controls
  output wire [7:0] white_peak_mode_out,
  output wire [1:0] channel_tag_format_out,
  output wire [1:0] white_peak_reference_out,
  output wire [1:0] white_peak_range_out,
  output wire [1:0] white_peak_time_constant_out,
  output reg video_out_enable_out
);

  // --------------------------------------------------------------------
  // State codes and shared functions
  // --------------------------------------------------------------------
  localparam ST_IDLE = 4'h0;
  localparam ST_ADDR = 4'h1;
  localparam ST_AACK = 4'h2;
  localparam ST_INDEX = 4'h3;
  localparam ST_IACK = 4'h4;
  localparam ST_WDATA = 4'h5;
  localparam ST_WACK = 4'h6;
  localparam ST_RDATA = 4'h7;
  localparam ST_RACK = 4'h8;

  // Reset value of a per-channel register
  function [7:0] reset_value;
    input [3:0] ofs;
    begin
      case (ofs)
        `OFS_INPUT_FORMAT_CONTROL: reset_value = `RST_INPUT_FORMAT_CONTROL;
        `OFS_HORIZ_START_LOW: reset_value = `RST_HORIZ_START_LOW;
        `OFS_HORIZ_WIDTH_LOW: reset_value = `RST_HORIZ_WIDTH_LOW;
        `OFS_VERT_START_LOW: reset_value = `RST_VERT_START_LOW;
        `OFS_VERT_HEIGHT_LOW: reset_value = `RST_VERT_HEIGHT_LOW;
        `OFS_WINDOW_UPPER_BITS: reset_value = `RST_WINDOW_UPPER_BITS;
        `OFS_HUE_ADJUST: reset_value = `RST_PICTURE_ADJUST;
        `OFS_SATURATION_ADJUST: reset_value = `RST_PICTURE_ADJUST;
        `OFS_CONTRAST_ADJUST: reset_value = `RST_PICTURE_ADJUST;
        `OFS_BRIGHTNESS_ADJUST: reset_value = `RST_PICTURE_ADJUST;
        `OFS_LUMA_FILTER_CONTROL: reset_value = `RST_LUMA_FILTER_CONTROL;
        `OFS_CHROMA_KILL_TRANSIENT: reset_value = `RST_CHROMA_KILL_TRANSIENT;
        `OFS_CHANNEL_OUTPUT_CONTROL: reset_value = `RST_CHANNEL_OUTPUT_CONTROL;
        `OFS_TEST_MODE_RESERVED: reset_value = `RST_TEST_MODE_RESERVED;
        default: reset_value = 8'h00;
      endcase
    end
  endfunction

  // Bits software may change; status and self-clearing bits excluded
  function [7:0] write_mask;
    input [3:0] ofs;
    begin
      case (ofs)
        `OFS_VIDEO_STATUS: write_mask = 8'h00;
        `OFS_INPUT_FORMAT_CONTROL: write_mask = `WMASK_INPUT_FORMAT_CONTROL;
        `OFS_WINDOW_UPPER_BITS: write_mask = `WMASK_WINDOW_UPPER_BITS;
        `OFS_CHROMA_KILL_TRANSIENT: write_mask = `WMASK_CHROMA_KILL_TRANSIENT;
        `OFS_CHANNEL_OUTPUT_CONTROL: write_mask = `WMASK_CHANNEL_OUTPUT_CONTROL;
        4'hF: write_mask = 8'h00;
        default: write_mask = 8'hFF;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Storage and pin synchronisers
  // --------------------------------------------------------------------
  reg [7:0] creg [0:63];
  reg [7:0] white_peak_modes;
  reg [7:0] white_peak_params;
  reg [7:0] misc_output_control;
  reg [2:0] sr_cnt [0:3];
  // Serial slave state
  reg scl_s1, scl_s2, scl_d;
  reg sda_s1, sda_s2, sda_d;
  reg [3:0] state;
  reg [3:0] bitcnt;
  reg [7:0] sh;
  reg [7:0] index;
  reg nack;
  reg [7:0] rd_byte;
  integer i, j;

  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire byte_done = scl_fall & (bitcnt == 4'h8);
  wire chan_space = (index[7:6] == 2'b00);
  wire wr_now = ce_in & byte_done & (state == ST_WDATA) & ~start_cond & ~stop_cond;
  wire [1:0] rd_ch = index[5:4];

  // Pin synchronisers and edge history
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce_in) begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  // --------------------------------------------------------------------
  // Read data, serial slave and register writes
  // --------------------------------------------------------------------
  // Byte returned for the current index
  always @* begin
    if (chan_space) begin
      case (index[3:0])
        `OFS_VIDEO_STATUS:
          rd_byte = {det_standard_in[rd_ch*3 +: 3], colour_detected_in[rd_ch],
                     colour_loop_locked_in[rd_ch], gain_loop_locked_in[rd_ch],
                     clamp_loop_locked_in[rd_ch], hpll_locked_in[rd_ch]};
        `OFS_INPUT_FORMAT_CONTROL:
          rd_byte = {creg[index[5:0]][7:2], nonstandard_input_in[rd_ch],
                     field_rate_sixty_in[rd_ch]};
        `OFS_CHANNEL_OUTPUT_CONTROL:
          rd_byte = {creg[index[5:0]][7:4], (sr_cnt[rd_ch] != 3'h0),
                     creg[index[5:0]][2:0]};
        default: rd_byte = creg[index[5:0]];
      endcase
    end else begin
      case (index)
        `ADDR_FIELD_VERT_HEIGHT_STATUS: rd_byte = {field_flag_in, vert_active_flag_in};
        `ADDR_WHITE_PEAK_MODES: rd_byte = white_peak_modes;
        `ADDR_WHITE_PEAK_PARAMS: rd_byte = white_peak_params;
        `ADDR_MISC_OUTPUT_CONTROL: rd_byte = misc_output_control;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Serial slave and register writes
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      sh <= 8'h00;
      index <= 8'h00;
      nack <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
      for (i = 0; i < 64; i = i + 1) begin
        creg[i] <= reset_value(i[3:0]);
      end
      white_peak_modes <= `RST_WHITE_PEAK_MODES;
      white_peak_params <= `RST_WHITE_PEAK_PARAMS;
      misc_output_control <= `RST_MISC_OUTPUT_CONTROL;
    end else if (ce_in) begin
      if (start_cond) begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_INDEX, ST_WDATA: begin
            if (scl_rise && bitcnt != 4'h8) begin
              sh <= {sh[6:0], sda_s2};
              bitcnt <= bitcnt + 4'h1;
            end else if (byte_done) begin
              bitcnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (sh[7:1] == {`SLAVE_ADDR_HIGH, slave_addr_sel_in}) begin
                  nack <= sh[0];
                  sda_oe_out <= 1'b1;
                  state <= ST_AACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else if (state == ST_INDEX) begin
                index <= sh;
                sda_oe_out <= 1'b1;
                state <= ST_IACK;
              end else begin
                if (chan_space) begin
                  creg[index[5:0]] <= (creg[index[5:0]] & ~write_mask(index[3:0])) |
                                      (sh & write_mask(index[3:0]));
                end else if (index == `ADDR_WHITE_PEAK_MODES) begin
                  white_peak_modes <= sh;
                end else if (index == `ADDR_WHITE_PEAK_PARAMS) begin
                  white_peak_params <= sh;
                end else if (index == `ADDR_MISC_OUTPUT_CONTROL) begin
                  misc_output_control <= sh;
                end
                index <= index + 8'h01;
                sda_oe_out <= 1'b1;
                state <= ST_WACK;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (nack) begin
                sh <= {rd_byte[6:0], 1'b0};
                sda_oe_out <= ~rd_byte[7];
                index <= index + 8'h01;
                state <= ST_RDATA;
              end else begin
                sda_oe_out <= 1'b0;
                state <= ST_INDEX;
              end
            end
          end
          ST_IACK, ST_WACK: begin
            if (scl_fall) begin
              sda_oe_out <= 1'b0;
              state <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              bitcnt <= bitcnt + 4'h1;
            end else if (byte_done) begin
              sda_oe_out <= 1'b0;
              bitcnt <= 4'h0;
              state <= ST_RACK;
            end else if (scl_fall) begin
              sda_oe_out <= ~sh[7];
              sh <= {sh[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack <= sda_s2;
            end else if (scl_fall) begin
              if (nack) begin
                state <= ST_IDLE;
              end else begin
                sh <= {rd_byte[6:0], 1'b0};
                sda_oe_out <= ~rd_byte[7];
                index <= index + 8'h01;
                state <= ST_RDATA;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Soft reset, derived controls and register field outputs
  // --------------------------------------------------------------------
  // Soft reset counters and derived channel controls
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (j = 0; j < 4; j = j + 1) begin
        sr_cnt[j] <= 3'h0;
      end
      soft_reset_out <= 4'h0;
      active_standard_out <= 12'h000;
      background_active_out <= 4'h0;
      background_black_out <= 4'h0;
      video_out_enable_out <= 1'b0;
    end else if (ce_in) begin
      for (j = 0; j < 4; j = j + 1) begin
        if (wr_now && chan_space && index[5:4] == j[1:0] &&
            index[3:0] == `OFS_CHANNEL_OUTPUT_CONTROL && sh[`BIT_SOFT_RESET]) begin
          sr_cnt[j] <= SOFT_RST_CYCLES[2:0];
        end else if (sr_cnt[j] != 3'h0) begin
          sr_cnt[j] <= sr_cnt[j] - 3'h1;
        end
        soft_reset_out[j] <= (sr_cnt[j] != 3'h0);
        active_standard_out[j*3 +: 3] <= creg[j*16+1][`BIT_MANUAL_STANDARD] | no_video_in[j] ?
            creg[j*16+1][6:4] : det_standard_in[j*3 +: 3];
        background_active_out[j] <= creg[j*16+13][`BIT_BACKGROUND_ENABLE];
        background_black_out[j] <= creg[j*16+13][`BIT_BACKGROUND_ENABLE] &
                                   creg[j*16+13][`BIT_BACKGROUND_COLOUR];
      end
      video_out_enable_out <= misc_output_control[`BIT_OUTPUT_ENABLE];
    end
  end

  // Per-channel field outputs taken from register storage
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      assign gain_loop_enable_out[g] = creg[g*16+1][`BIT_GAIN_LOOP_ENABLE];
      assign setup_level_select_out[g] = creg[g*16+1][`BIT_SETUP_LEVEL];
      assign horiz_start_out[g*10 +: 10] = {creg[g*16+6][1:0], creg[g*16+2]};
      assign horiz_width_out[g*10 +: 10] = {creg[g*16+6][3:2], creg[g*16+3]};
      assign vert_start_out[g*9 +: 9] = {creg[g*16+6][4], creg[g*16+4]};
      assign vert_height_out[g*9 +: 9] = {creg[g*16+6][5], creg[g*16+5]};
      assign hue_out[g*8 +: 8] = creg[g*16+7];
      assign saturation_gain_out[g*8 +: 8] = creg[g*16+8];
      assign contrast_gain_out[g*8 +: 8] = creg[g*16+9];
      assign brightness_offset_out[g*8 +: 8] = creg[g*16+10];
      assign trap_bandwidth_out[g] = creg[g*16+11][7];
      assign separation_mode_out[g*2 +: 2] = creg[g*16+11][6:5];
      assign peaking_band_out[g] = creg[g*16+11][4];
      assign peaking_gain_out[g*4 +: 4] = creg[g*16+11][3:0];
      assign colour_kill_mode_out[g*2 +: 2] = creg[g*16+12][5:4];
      assign transient_gain_out[g*4 +: 4] = creg[g*16+12][3:0];
      assign dual_output_enable_out[g] = creg[g*16+13][`BIT_DUAL_OUTPUT];
      assign partner_channel_select_out[g*2 +: 2] = creg[g*16+13][1:0];
    end
  endgenerate
  // Shared white peak and tag fields
  assign white_peak_mode_out = white_peak_modes;
  assign channel_tag_format_out = white_peak_params[7:6];
  assign white_peak_reference_out = white_peak_params[5:4];
  assign white_peak_range_out = white_peak_params[3:2];
  assign white_peak_time_constant_out = white_peak_params[1:0];

endmodule

// ==== testbench/video_decoder_channel_controls_chk.sv ====
module video_decoder_channel_controls_chk #(
  parameter SOFT_RST_CYCLES = 4
) (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Observed pins
  input wire scl_in,
  input wire [3:0] background_active_out,
  input wire [3:0] background_black_out,
  input wire [3:0] soft_reset_out,
  input wire video_out_enable_out,
  input wire [39:0] horiz_start_out,
  input wire [31:0] hue_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] sr_cnt;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Length of the running soft-reset pulse
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) sr_cnt <= 4'h0;
    else sr_cnt <= soft_reset_out[0] ? sr_cnt + 4'h1 : 4'h0;
  end
  property p_bg_pair; (background_black_out & ~background_active_out) == 4'h0; endproperty
  a_bg_pair: assert property (p_bg_pair) else $error("black without background");
  property p_bg_upd; $changed(background_active_out) |-> !scl_in; endproperty
  a_bg_upd: assert property (p_bg_upd) else $error("background moved off a write");
  property p_sr_len; $fell(soft_reset_out[0]) |-> sr_cnt == SOFT_RST_CYCLES; endproperty
  a_sr_len: assert property (p_sr_len) else $error("soft reset pulse length");
  property p_sr_max; sr_cnt <= SOFT_RST_CYCLES; endproperty
  a_sr_max: assert property (p_sr_max) else $error("soft reset not clearing");
  property p_sr_start; $rose(soft_reset_out[0]) |-> !scl_in; endproperty
  a_sr_start: assert property (p_sr_start) else $error("soft reset off a write");
  property p_oe_upd; $changed(video_out_enable_out) |-> !scl_in; endproperty
  a_oe_upd: assert property (p_oe_upd) else $error("output enable moved");
  property p_win_upd; $changed(horiz_start_out) |-> !scl_in; endproperty
  a_win_upd: assert property (p_win_upd) else $error("window start moved");
  property p_hue_upd; $changed(hue_out) |-> !scl_in; endproperty
  a_hue_upd: assert property (p_hue_upd) else $error("hue moved");
  cover property ($fell(soft_reset_out[0]));
  cover property ($rose(video_out_enable_out));
  cover property ($rose(background_black_out[0]));
endmodule

// ==== testbench/serial_host_model.sv ====
module serial_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h29
) (
  // Clock
  input wire logic clk_in,
  // Bus lines
  input wire logic sda_oe_in,
  output logic scl_out,
  output wire logic sda_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pull_low = 1'b0;
  logic [6:0] dev = DEV_ADDR;
  // Open-drain data line with pull-up
  assign sda_out = ~(pull_low | sda_oe_in);
  initial scl_out = 1'b1;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic put(input logic b);
    pull_low = ~b;
    tick(6);
    scl_out = 1'b1;
    tick(10);
    scl_out = 1'b0;
    tick(6);
  endtask
  task automatic get(output logic b);
    pull_low = 1'b0;
    tick(6);
    scl_out = 1'b1;
    tick(5);
    b = sda_out;
    tick(5);
    scl_out = 1'b0;
    tick(6);
  endtask
  task automatic start;
    pull_low = 1'b0;
    tick(6);
    scl_out = 1'b1;
    tick(10);
    pull_low = 1'b1;
    tick(10);
    scl_out = 1'b0;
    tick(6);
  endtask
  task automatic stop;
    pull_low = 1'b1;
    tick(6);
    scl_out = 1'b1;
    tick(10);
    pull_low = 1'b0;
    tick(10);
  endtask
  task automatic send(input logic [7:0] d, inout logic ok);
    logic b;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(b);
    ok &= ~b;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start;
    send({dev, 1'b0}, ok);
    send(idx, ok);
    send(d, ok);
    stop;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic ok);
    ok = 1'b1;
    start;
    send({dev, 1'b0}, ok);
    send(idx, ok);
    start;
    send({dev, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    stop;
  endtask
endmodule

// ==== testbench/tb.sv ====
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [11:0] det = 12'h000;
  logic [3:0] lk = 4'h0;
  logic [3:0] nov = 4'h0;
  logic [3:0] field_flag = 4'h0;
  logic [3:0] vert_active_flag = 4'h0;
  wire scl, sda, sda_oe, oe;
  wire [39:0] hs, hw;
  wire [35:0] vs, vh;
  wire [31:0] hue;
  wire [15:0] tg;
  wire [11:0] std;
  wire [7:0] wpm, psel;
  wire [3:0] gle, bga, bgb, srs, sls, dop;
  wire [1:0] ctf, wpr, wpg, wpt;
  logic [7:0] rd;
  logic ok;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int n = 0;
  logic [15:0] rv [18] = '{16'h0100, 16'h0220, 16'h03D0, 16'h0406, 16'h05F0, 16'h0608,
    16'h0780, 16'h0880, 16'h0980, 16'h0A80, 16'h0B00, 16'h0C06, 16'h0D00, 16'h0E11,
    16'h1220, 16'h4100, 16'h4200, 16'h4300};
  video_decoder_channel_controls #(.SOFT_RST_CYCLES(4)) uut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe_out(sda_oe), .slave_addr_sel_in(2'h1), .det_standard_in(det),
    .colour_detected_in(lk), .colour_loop_locked_in(lk), .gain_loop_locked_in(lk),
    .clamp_loop_locked_in(lk), .hpll_locked_in(lk), .nonstandard_input_in(lk),
    .field_rate_sixty_in(lk), .no_video_in(nov), .field_flag_in(field_flag), .vert_active_flag_in(vert_active_flag),
    .active_standard_out(std), .gain_loop_enable_out(gle), .setup_level_select_out(sls),
    .horiz_start_out(hs), .horiz_width_out(hw), .vert_start_out(vs), .vert_height_out(vh),
    .hue_out(hue), .saturation_gain_out(), .contrast_gain_out(), .brightness_offset_out(),
    .trap_bandwidth_out(), .separation_mode_out(), .peaking_band_out(), .peaking_gain_out(),
    .colour_kill_mode_out(), .transient_gain_out(tg), .background_active_out(bga),
    .background_black_out(bgb), .soft_reset_out(srs), .dual_output_enable_out(dop),
    .partner_channel_select_out(psel), .white_peak_mode_out(wpm), .channel_tag_format_out(ctf),
    .white_peak_reference_out(wpr), .white_peak_range_out(wpg),
    .white_peak_time_constant_out(wpt), .video_out_enable_out(oe));
  serial_host_model host (.clk_in(clk_in), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
  always #5 clk_in = ~clk_in;
  // Hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      test_done;
    end
  end
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic w(input logic [7:0] i, input logic [7:0] d);
    host.wr(i, d, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic r(input logic [7:0] i, input logic [7:0] e);
    host.rd(i, rd, ok);
    `CHK({ok, rd}, {1'b1, e})
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    @(posedge clk_in);
    #1;
    `CHK({hw[9:0], vh[8:0], hs[9:0], vs[8:0]}, {10'h2D0, 9'h0F0, 10'h020, 9'h006})
    `CHK({hue[7:0], tg[3:0], oe}, {8'h80, 4'h6, 1'b0})
    for (int k = 0; k < 18; k++) r(rv[k][15:8], rv[k][7:0]);
    lk = 4'h1;
    det = 12'h002;
    r(8'h00, 8'h5F);
    w(8'h01, 8'hEC);
    `CHK({std[2:0], gle[0], sls[0]}, {3'h6, 2'h3})
    r(8'h01, 8'hEF);
    w(8'h01, 8'h40);
    `CHK(std[2:0], 3'h2)
    nov = 4'h1;
    repeat (2) @(posedge clk_in);
    #1;
    `CHK(std[2:0], 3'h4)
    w(8'h06, 8'hFF);
    `CHK({hs[9:0], hw[9:0], vs[8:0], vh[8:0]}, {10'h320, 10'h3D0, 9'h106, 9'h1F0})
    r(8'h06, 8'h3F);
    w(8'h17, 8'h11);
    `CHK(hue[15:0], 16'h1180)
    w(8'h0D, 8'h67);
    `CHK({bga[0], bgb[0], dop[0], psel[1:0]}, 5'h1F)
    w(8'h0D, 8'h20);
    `CHK({bga[0], bgb[0], dop[0], psel[1:0]}, 5'h00)
    fork
      w(8'h0D, 8'h08);
      repeat (900) @(posedge clk_in) n += srs[0];
    join
    `CHK(n, 4)
    r(8'h0D, 8'h00);
    r(8'h17, 8'h11);
    field_flag = 4'hA;
    vert_active_flag = 4'h5;
    w(8'h40, 8'h00);
    r(8'h40, 8'hA5);
    w(8'h41, 8'h1B);
    w(8'h42, 8'hE4);
    `CHK({wpm, ctf, wpr, wpg, wpt}, {8'h1B, 2'h3, 2'h2, 2'h1, 2'h0})
    w(8'h43, 8'h80);
    `CHK(oe, 1'b1)
    w(8'h50, 8'hFF);
    r(8'h50, 8'h00);
    host.dev = 7'h2A;
    host.wr(8'h43, 8'h00, ok);
    `CHK({ok, oe}, 2'h1)
    host.dev = 7'h29;
    test_done;
  end
endmodule
bind video_decoder_channel_controls video_decoder_channel_controls_chk #(
  .SOFT_RST_CYCLES(SOFT_RST_CYCLES)) chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .scl_in(scl_in), .background_active_out(background_active_out),
  .background_black_out(background_black_out), .soft_reset_out(soft_reset_out),
  .video_out_enable_out(video_out_enable_out), .horiz_start_out(horiz_start_out),
  .hue_out(hue_out));
